//--- hdl/ssc_blink.sv
/*
 Ready indicator pattern generator: fast blink, slow blink or steady on.
 Assumes the mode input comes from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module ssc_blink #(
   parameter int FAST_HALF = ssc_pkg::FAST_HALF_CYC,
   parameter int SLOW_HALF = ssc_pkg::SLOW_HALF_CYC
) (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic [1:0] mode,
   output logic led_q
);
   logic [31:0] cnt_q;
   logic [31:0] half;
   logic [1:0] mode_q;

   // Half period for the present mode
   assign half = (mode == ssc_pkg::RPT_RUN) ? 32'(FAST_HALF - 1) :
                 32'(SLOW_HALF - 1);

   // Phase counter restarts when the mode changes
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_q <= 32'h00000000;
         mode_q <= ssc_pkg::RPT_RDY;
      end else begin
         mode_q <= mode;
         if (mode != mode_q || cnt_q >= half) begin
            cnt_q <= 32'h00000000;
         end else begin
            cnt_q <= cnt_q + 32'h00000001;
         end
      end
   end

   // Steady in ready, toggling otherwise
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         led_q <= 1'b1;
      end else if (mode == ssc_pkg::RPT_RDY) begin
         led_q <= 1'b1;
      end else if (mode != mode_q) begin
         led_q <= 1'b0;
      end else if (cnt_q >= half) begin
         led_q <= ~led_q;
      end
   end
endmodule
`default_nettype wire

//--- hdl/ssc_pkg.sv
/*
 Shared constants for the setpoint sequence controller: register offsets,
 field positions, reset values, command codes, states and timing counts.
 Assumes a 20 MHz core clock and a 32-bit APB register bus.
*/
package ssc_pkg;
   // Location storage range
   localparam int LOC_W = 8;
   localparam int VAL_W = 16;
   localparam logic [7:0] LOC_MIN = 8'h0B;
   localparam logic [7:0] LOC_MAX = 8'hFF;

   // Register byte offsets
   localparam logic [11:0] A_CMD = 12'h000;
   localparam logic [11:0] A_START = 12'h004;
   localparam logic [11:0] A_STOP = 12'h008;
   localparam logic [11:0] A_REP = 12'h00C;
   localparam logic [11:0] A_TDEF = 12'h010;
   localparam logic [11:0] A_LADDR = 12'h014;
   localparam logic [11:0] A_LVSET = 12'h018;
   localparam logic [11:0] A_LISET = 12'h01C;
   localparam logic [11:0] A_LDWELL = 12'h020;
   localparam logic [11:0] A_LCTRL = 12'h024;
   localparam logic [11:0] A_STATUS = 12'h028;
   localparam logic [11:0] A_RREP = 12'h02C;
   localparam logic [11:0] A_EVENT2 = 12'h030;
   localparam logic [11:0] A_OUTPTS = 12'h034;

   // Field positions
   localparam int OWN_DWELL_BIT = 16;
   localparam int STORE_BIT = 0;
   localparam int ERASE_BIT = 1;
   localparam int FAULT_BIT = 5;

   // Reset values
   localparam logic [7:0] START_RST = 8'h0B;
   localparam logic [7:0] STOP_RST = 8'h0B;
   localparam logic [15:0] REP_RST = 16'h0000;
   localparam logic [15:0] TDEF_RST = 16'h0064;

   // Command codes written to the command register
   localparam logic [2:0] CMD_STOP = 3'h1;
   localparam logic [2:0] CMD_HOLD = 3'h2;
   localparam logic [2:0] CMD_CONT = 3'h3;
   localparam logic [2:0] CMD_ENDCUR = 3'h4;
   localparam logic [2:0] CMD_GO = 3'h5;
   localparam logic [2:0] CMD_STEP = 3'h6;
   localparam logic [2:0] CMD_START = 3'h7;

   // State codes as reported in the status register
   localparam logic [1:0] RPT_RDY = 2'h0;
   localparam logic [1:0] RPT_RUN = 2'h1;
   localparam logic [1:0] RPT_HOLD = 2'h2;

   typedef enum logic [1:0] {SSC_RDY, SSC_RUN, SSC_HOLD} ssc_state_e;

   // Timing: dwell unit and indicator blink half periods
   localparam int CLK_PERIOD_NS = 50;
   localparam int DWELL_UNIT_NS = 10_000_000;
   localparam int FAST_HALF_NS = 125_000_000;
   localparam int SLOW_HALF_NS = 500_000_000;
   localparam int DWELL_TICK_CYC = DWELL_UNIT_NS / CLK_PERIOD_NS;
   localparam int FAST_HALF_CYC = FAST_HALF_NS / CLK_PERIOD_NS;
   localparam int SLOW_HALF_CYC = SLOW_HALF_NS / CLK_PERIOD_NS;
endpackage

//--- hdl/ssc_top.sv
/*
 Setpoint sequence controller: location store, run/hold/ready sequencer,
 dwell timing, repetition count, fault flag and APB register slave.
 Assumes an APB master on core_clk and a confirm key pin from outside.
*/
// Decided for this implementation: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - stop ends sequence via stop location, ready
// - stop loads stop setpoints, empty keeps last
// - stop: empty location forces output off
// - hold freezes setpoints, output and dwell
// - hold accepts six follow-up commands
// - resume runs next location with its dwell
// - confirm key twice advances early
// - end at current keeps everything, ready
// - restart: output on, run start to stop
// - step loads next, stays held, step mode
// - step wrap keeps repetitions counter
// - start location, hold, output on, reload repetitions
// - indicator fast in run, slow hold, steady
// - locations 11 through 255 only
// - state readable as run, hold or ready
// - sequence error sets bit 5 of event_reg_two
module ssc_top #(
   parameter int TICK_CYCLES = ssc_pkg::DWELL_TICK_CYC,
   parameter int FAST_HALF = ssc_pkg::FAST_HALF_CYC,
   parameter int SLOW_HALF = ssc_pkg::SLOW_HALF_CYC
) (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic confirm_key,
   output logic [15:0] vset,
   output logic [15:0] iset,
   output logic out_on,
   output logic ready_led
);
   ssc_pkg::ssc_state_e st_q, st_d;
   logic [7:0] start_q, stop_q, cur_q, laddr_q, tgt, nxt_loc;
   logic [15:0] rep_q, rrep_q, tdef_q, lv_q, li_q, dwell_q;
   logic [16:0] ld_q;
   logic [15:0] mem_v_q [256];
   logic [15:0] mem_i_q [256];
   logic [16:0] mem_t_q [256];
   logic [255:0] mem_ok_q;
   logic [31:0] tick_cnt_q;
   logic step_q, step_d, fault_q, pready_q, pslverr_q;
   logic [31:0] prdata_q;
   logic [15:0] vset_q, iset_q;
   logic out_on_q, led_q;
   logic k1_q, k2_q, k3_q, key_lvl_q, key_press;
   logic acc, wr_en, rd_cyc, mapped, cmd_wr;
   logic [2:0] cmd;
   logic c_stop, c_hold, c_cont, c_end, c_go, c_step, c_start;
   logic tick, adv, cfg_ok, ld, chk, dw_ld, out_set, out_clr;
   logic rep_ld, rep_dec, fault_ev;
   logic [1:0] st_code;

   // APB handshake: one wait state, answer registered
   assign acc = psel & penable;
   assign wr_en = acc & pwrite & pready_q;
   assign rd_cyc = acc & ~pready_q;
   assign mapped = paddr inside {ssc_pkg::A_CMD, ssc_pkg::A_START,
      ssc_pkg::A_STOP, ssc_pkg::A_REP, ssc_pkg::A_TDEF, ssc_pkg::A_LADDR,
      ssc_pkg::A_LVSET, ssc_pkg::A_LISET, ssc_pkg::A_LDWELL,
      ssc_pkg::A_LCTRL, ssc_pkg::A_STATUS, ssc_pkg::A_RREP,
      ssc_pkg::A_EVENT2, ssc_pkg::A_OUTPTS};

   // Reported state code
   always_comb begin
      case (st_q)
         ssc_pkg::SSC_RUN: st_code = ssc_pkg::RPT_RUN;
         ssc_pkg::SSC_HOLD: st_code = ssc_pkg::RPT_HOLD;
         default: st_code = ssc_pkg::RPT_RDY;
      endcase
   end

   // Ready and read data for the access phase
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h00000000;
      end else begin
         pready_q <= rd_cyc;
         pslverr_q <= rd_cyc & ~mapped;
         prdata_q <= 32'h00000000;
         if (rd_cyc && !pwrite) begin
            case (paddr)
               ssc_pkg::A_START: prdata_q <= {24'h000000, start_q};
               ssc_pkg::A_STOP: prdata_q <= {24'h000000, stop_q};
               ssc_pkg::A_REP: prdata_q <= {16'h0000, rep_q};
               ssc_pkg::A_TDEF: prdata_q <= {16'h0000, tdef_q};
               ssc_pkg::A_LADDR: prdata_q <= {24'h000000, laddr_q};
               ssc_pkg::A_LVSET: prdata_q <= {16'h0000, lv_q};
               ssc_pkg::A_LISET: prdata_q <= {16'h0000, li_q};
               ssc_pkg::A_LDWELL: prdata_q <= {15'h0000, ld_q};
               ssc_pkg::A_STATUS: prdata_q <= {16'h0000, cur_q, 4'h0,
                  out_on_q, step_q, st_code};
               ssc_pkg::A_RREP: prdata_q <= {16'h0000, rrep_q};
               ssc_pkg::A_EVENT2: prdata_q <= 32'(fault_q) << ssc_pkg::FAULT_BIT;
               ssc_pkg::A_OUTPTS: prdata_q <= {iset_q, vset_q};
               default: prdata_q <= 32'h00000000;
            endcase
         end
      end
   end

   // Configuration and staging registers
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         start_q <= ssc_pkg::START_RST;
         stop_q <= ssc_pkg::STOP_RST;
         rep_q <= ssc_pkg::REP_RST;
         tdef_q <= ssc_pkg::TDEF_RST;
         laddr_q <= ssc_pkg::LOC_MIN;
         lv_q <= 16'h0000;
         li_q <= 16'h0000;
         ld_q <= 17'h00000;
      end else if (wr_en) begin
         case (paddr)
            ssc_pkg::A_START: start_q <= pwdata[7:0];
            ssc_pkg::A_STOP: stop_q <= pwdata[7:0];
            ssc_pkg::A_REP: rep_q <= pwdata[15:0];
            ssc_pkg::A_TDEF: tdef_q <= pwdata[15:0];
            ssc_pkg::A_LADDR: laddr_q <= pwdata[7:0];
            ssc_pkg::A_LVSET: lv_q <= pwdata[15:0];
            ssc_pkg::A_LISET: li_q <= pwdata[15:0];
            ssc_pkg::A_LDWELL: ld_q <= pwdata[16:0];
            default: ;
         endcase
      end
   end

   // Location store; addresses below the sequence range are never kept
   always_ff @(posedge core_clk) begin
      if (wr_en && paddr == ssc_pkg::A_LCTRL && pwdata[ssc_pkg::STORE_BIT]
          && laddr_q >= ssc_pkg::LOC_MIN) begin
         mem_v_q[laddr_q] <= lv_q;
         mem_i_q[laddr_q] <= li_q;
         mem_t_q[laddr_q] <= ld_q;
      end
   end

   // Occupied marks per location
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         mem_ok_q <= '0;
      end else if (wr_en && paddr == ssc_pkg::A_LCTRL
                   && laddr_q >= ssc_pkg::LOC_MIN) begin
         if (pwdata[ssc_pkg::STORE_BIT]) begin
            mem_ok_q[laddr_q] <= 1'b1;
         end else if (pwdata[ssc_pkg::ERASE_BIT]) begin
            mem_ok_q[laddr_q] <= 1'b0;
         end
      end
   end

   // Confirm key: three-stage synchroniser, change once stages 2 and 3 agree
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         k1_q <= 1'b0;
         k2_q <= 1'b0;
         k3_q <= 1'b0;
         key_lvl_q <= 1'b0;
      end else begin
         k1_q <= confirm_key;
         k2_q <= k1_q;
         k3_q <= k2_q;
         if (k2_q == k3_q) begin
            key_lvl_q <= k3_q;
         end
      end
   end
   assign key_press = (k2_q == k3_q) & k3_q & ~key_lvl_q;

   // Command decode; a register write wins over a key press
   assign cmd_wr = wr_en & (paddr == ssc_pkg::A_CMD);
   always_comb begin
      cmd = 3'h0;
      if (cmd_wr) begin
         cmd = pwdata[2:0];
      end else if (key_press) begin
         case (st_q)
            ssc_pkg::SSC_RUN: cmd = ssc_pkg::CMD_HOLD;
            ssc_pkg::SSC_HOLD: cmd = ssc_pkg::CMD_CONT;
            default: cmd = ssc_pkg::CMD_GO;
         endcase
      end
   end
   assign c_stop = cmd == ssc_pkg::CMD_STOP;
   assign c_hold = cmd == ssc_pkg::CMD_HOLD;
   assign c_cont = cmd == ssc_pkg::CMD_CONT;
   assign c_end = cmd == ssc_pkg::CMD_ENDCUR;
   assign c_go = cmd == ssc_pkg::CMD_GO;
   assign c_step = cmd == ssc_pkg::CMD_STEP;
   assign c_start = cmd == ssc_pkg::CMD_START;

   // Next location wraps at or past stop, so a stop moved below the
   // running location cannot carry the count past the top of the range
   assign nxt_loc = (cur_q >= stop_q) ? start_q : cur_q + 8'h01;
   assign cfg_ok = start_q >= ssc_pkg::LOC_MIN && start_q <= stop_q;
   assign tick = st_q == ssc_pkg::SSC_RUN
      && tick_cnt_q == 32'(TICK_CYCLES - 1);
   assign adv = tick && dwell_q <= 16'h0001;

   // Sequencer decisions
   always_comb begin
      st_d = st_q;
      tgt = cur_q;
      ld = 1'b0;
      chk = 1'b0;
      dw_ld = 1'b0;
      out_set = 1'b0;
      out_clr = 1'b0;
      rep_ld = 1'b0;
      rep_dec = 1'b0;
      step_d = step_q;
      fault_ev = 1'b0;
      if ((c_go || c_start) && !cfg_ok) begin
         fault_ev = 1'b1;
      end else if (c_go) begin
         st_d = ssc_pkg::SSC_RUN;
         tgt = start_q;
         ld = 1'b1;
         chk = 1'b1;
         dw_ld = 1'b1;
         out_set = 1'b1;
         rep_ld = 1'b1;
         step_d = 1'b0;
      end else if (st_q != ssc_pkg::SSC_RDY) begin
         if (c_stop) begin
            st_d = ssc_pkg::SSC_RDY;
            tgt = stop_q;
            ld = 1'b1;
            out_clr = ~mem_ok_q[stop_q];
         end else if (c_start) begin
            st_d = ssc_pkg::SSC_HOLD;
            tgt = start_q;
            ld = 1'b1;
            chk = 1'b1;
            out_set = 1'b1;
            rep_ld = 1'b1;
            step_d = 1'b1;
         end else if (st_q == ssc_pkg::SSC_RUN) begin
            if (c_hold) begin
               st_d = ssc_pkg::SSC_HOLD;
            end else if (adv) begin
               if (cur_q == stop_q && rrep_q == 16'h0000) begin
                  st_d = ssc_pkg::SSC_RDY;
               end else begin
                  tgt = nxt_loc;
                  ld = 1'b1;
                  chk = 1'b1;
                  dw_ld = 1'b1;
                  rep_dec = cur_q == stop_q;
               end
            end
         end else if (c_cont) begin
            st_d = ssc_pkg::SSC_RUN;
            tgt = nxt_loc;
            ld = 1'b1;
            chk = 1'b1;
            dw_ld = 1'b1;
         end else if (c_end) begin
            st_d = ssc_pkg::SSC_RDY;
         end else if (c_step) begin
            tgt = nxt_loc;
            ld = 1'b1;
            chk = 1'b1;
            step_d = 1'b1;
         end
      end
      if (chk && !mem_ok_q[tgt]) begin
         fault_ev = 1'b1;
      end
   end

   // Sequencer state, location, repetitions and mode
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         st_q <= ssc_pkg::SSC_RDY;
         cur_q <= ssc_pkg::START_RST;
         rrep_q <= ssc_pkg::REP_RST;
         step_q <= 1'b0;
      end else begin
         st_q <= st_d;
         step_q <= step_d;
         if (ld) begin
            cur_q <= tgt;
         end
         if (rep_ld) begin
            rrep_q <= rep_q;
         end else if (rep_dec) begin
            rrep_q <= rrep_q - 16'h0001;
         end
      end
   end

   // Setpoints and output switch
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         vset_q <= 16'h0000;
         iset_q <= 16'h0000;
         out_on_q <= 1'b0;
      end else begin
         if (ld && mem_ok_q[tgt]) begin
            vset_q <= mem_v_q[tgt];
            iset_q <= mem_i_q[tgt];
         end
         if (out_set) begin
            out_on_q <= 1'b1;
         end else if (out_clr) begin
            out_on_q <= 1'b0;
         end
      end
   end

   // Dwell timing; frozen outside run
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         tick_cnt_q <= 32'h00000000;
         dwell_q <= 16'h0000;
      end else if (dw_ld) begin
         tick_cnt_q <= 32'h00000000;
         // Empty location falls back to the default, never unset storage
         dwell_q <= (mem_ok_q[tgt] && mem_t_q[tgt][ssc_pkg::OWN_DWELL_BIT]) ?
            mem_t_q[tgt][15:0] : tdef_q;
      end else if (tick) begin
         tick_cnt_q <= 32'h00000000;
         dwell_q <= dwell_q - 16'h0001;
      end else if (st_q == ssc_pkg::SSC_RUN) begin
         tick_cnt_q <= tick_cnt_q + 32'h00000001;
      end
   end

   // Sequence fault flag, write one to clear, a new event wins
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         fault_q <= 1'b0;
      end else if (fault_ev) begin
         fault_q <= 1'b1;
      end else if (wr_en && paddr == ssc_pkg::A_EVENT2
                   && pwdata[ssc_pkg::FAULT_BIT]) begin
         fault_q <= 1'b0;
      end
   end

   ssc_blink #(.FAST_HALF(FAST_HALF), .SLOW_HALF(SLOW_HALF)) u_blink (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .mode(st_code),
      .led_q(led_q)
   );

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign vset = vset_q;
   assign iset = iset_q;
   assign out_on = out_on_q;
   assign ready_led = led_q;

   // Checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   logic stop_cmd, stop_empty;
   assign stop_cmd = c_stop && st_q != ssc_pkg::SSC_RDY && !c_go && !c_start;
   assign stop_empty = ~mem_ok_q[stop_q];

   a_stop_ready: assert property (stop_cmd |=> st_q == ssc_pkg::SSC_RDY
      && cur_q == $past(stop_q)) else $error("stop did not end");
   a_stop_keep: assert property (stop_cmd && stop_empty |=> $stable(vset_q)
      && $stable(iset_q)) else $error("stop lost setpoints");
   a_stop_off: assert property (stop_cmd && stop_empty |=> !out_on_q)
      else $error("stop left output on");
   a_hold_freeze: assert property (st_q == ssc_pkg::SSC_HOLD
      && $past(st_q) == ssc_pkg::SSC_HOLD |-> $stable(dwell_q)
      && $stable(tick_cnt_q)) else $error("dwell moved in hold");
   a_cont_next: assert property (st_q == ssc_pkg::SSC_HOLD && c_cont
      && !cmd_wr |=> st_q == ssc_pkg::SSC_RUN && cur_q == $past(nxt_loc))
      else $error("key resume wrong");
   a_resume_run: assert property (st_q == ssc_pkg::SSC_HOLD && c_cont
      |=> st_q == ssc_pkg::SSC_RUN && $stable(out_on_q)
      && tick_cnt_q == 32'h00000000) else $error("resume wrong");
   a_end_cur: assert property (st_q == ssc_pkg::SSC_HOLD && c_end
      |=> st_q == ssc_pkg::SSC_RDY && $stable(out_on_q) && $stable(vset_q))
      else $error("end at current wrong");
   a_go_run: assert property (c_go && cfg_ok |=> st_q == ssc_pkg::SSC_RUN
      && out_on_q && cur_q == $past(start_q)) else $error("restart");
   a_step_hold: assert property (st_q == ssc_pkg::SSC_HOLD && c_step
      |=> st_q == ssc_pkg::SSC_HOLD && step_q && $stable(rrep_q)
      && $stable(out_on_q)) else $error("step wrong");
   a_start_hold: assert property (st_q != ssc_pkg::SSC_RDY && c_start
      && cfg_ok && !c_go |=> st_q == ssc_pkg::SSC_HOLD && out_on_q
      && rrep_q == $past(rep_q) && step_q) else $error("start");
   a_led_steady: assert property (st_q == ssc_pkg::SSC_RDY [*2] |-> led_q)
      else $error("indicator blinks in ready");
   a_loc_range: assert property (st_q != ssc_pkg::SSC_RDY
      |-> cur_q >= ssc_pkg::LOC_MIN) else $error("location range");
   a_fault_set: assert property (fault_ev |=> fault_q)
      else $error("fault flag missed");
   a_loop_end: assert property (adv && cur_q == stop_q && rrep_q == 16'h0000
      && cmd == 3'h0 |=> st_q == ssc_pkg::SSC_RDY)
      else $error("loop end missed");

   c_run_hold: cover property (st_q == ssc_pkg::SSC_RUN
      ##1 st_q == ssc_pkg::SSC_HOLD);
   c_hold_run: cover property (st_q == ssc_pkg::SSC_HOLD
      ##1 st_q == ssc_pkg::SSC_RUN);
   c_wrap: cover property (rep_dec);
   c_stop_off: cover property (stop_cmd && stop_empty && out_on_q);
endmodule
`default_nettype wire

//--- verification/ssc_key_model.sv
/*
 Front panel confirm key model: each press request holds the key down
 for six core clock cycles, then lets it go back to its idle low level.
 Assumes press requests come from the bench on core_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module ssc_key_model (
   input wire logic core_clk,
   input wire logic press,
   output logic confirm_key
);
   logic [2:0] hold_q = 3'h0;

   // Counts down the time the key stays pressed
   always @(posedge core_clk) begin
      if (press) begin
         hold_q <= 3'h6;
      end else if (hold_q != 3'h0) begin
         hold_q <= hold_q - 3'h1;
      end
   end

   // Released key reads low, like a pulled-down contact
   assign confirm_key = (hold_q != 3'h0);
endmodule
`default_nettype wire

//--- verification/tb_top.sv
/*
 Self-checking bench for the setpoint sequence controller over APB.
 Assumes the controller top, its package and the key model are compiled.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam logic [31:0] F = 32'hFFFFFFFF;
   localparam logic [31:0] S = 32'h0000FF0F;
   localparam logic [31:0] R = 32'h0000FF0B;
   localparam logic [11:0] ST = ssc_pkg::A_STATUS;
   localparam logic [11:0] OP = ssc_pkg::A_OUTPTS;
   localparam logic [11:0] RR = ssc_pkg::A_RREP;
   localparam logic [11:0] EV = ssc_pkg::A_EVENT2;
   logic core_clk = 1'b0;
   logic reset_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic key_req = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic [15:0] vset, iset;
   logic pready, pslverr, confirm_key, out_on, ready_led;
   logic [15:0] v [3];
   logic [15:0] c [3];
   logic [64:0] exp_q [$];
   logic [64:0] e;
   int error_cnt = 0;
   int samples_checked = 0;

   // Core clock, 50 ns period
   always #25 core_clk = ~core_clk;

   ssc_top #(.TICK_CYCLES(4), .FAST_HALF(3), .SLOW_HALF(6)) dut (
      .core_clk(core_clk), .reset_n(reset_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .confirm_key(confirm_key), .vset(vset), .iset(iset),
      .out_on(out_on), .ready_led(ready_led));

   ssc_key_model key_model (
      .core_clk(core_clk), .press(key_req), .confirm_key(confirm_key));

   task automatic chk(input string nm, input logic [32:0] x,
                      input logic [32:0] g);
      samples_checked++;
      if (g !== x) begin
         error_cnt++;
         $display("mismatch %s exp %h got %h", nm, x, g);
      end
   endtask

   // Compares the setpoint and output switch pins, which stand as levels
   task automatic pins(input logic [15:0] xv, input logic [15:0] xc,
                       input logic xo);
      chk("vset", 33'(xv), 33'(vset));
      chk("iset", 33'(xc), 33'(iset));
      chk("out_on", 33'(xo), 33'(out_on));
   endtask

   // One APB transfer, held until pready is sampled high
   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         error_cnt++;
         summarize();
      end
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   // Notes the expected masked read value, then reads
   task automatic rd(input logic [11:0] a, input logic [31:0] x,
                     input logic [31:0] m, input logic err = 1'b0);
      exp_q.push_back({m, err, x & m});
      apb(1'b0, a, 32'h0);
   endtask

   task automatic cmd(input logic [2:0] k);
      wr(ssc_pkg::A_CMD, 32'(k));
   endtask

   task automatic key();
      key_req <= 1'b1;
      @(posedge core_clk);
      key_req <= 1'b0;
      repeat (12) @(posedge core_clk);
   endtask

   // Counts indicator toggles over a window and checks the range
   task automatic led(input int cyc, input int lo, input int hi);
      int t;
      logic p;
      t = 0;
      p = ready_led;
      repeat (cyc) begin
         @(posedge core_clk);
         if (ready_led !== p) t++;
         p = ready_led;
      end
      chk("led toggles", 33'h1, 33'(t >= lo && t <= hi));
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // Takes the oldest note whenever read data is handed back
   always @(posedge core_clk) begin
      if (psel && penable && pready === 1'b1 && !pwrite) begin
         if (exp_q.size() == 0) begin
            chk("read queue", 33'h0, 33'h1);
         end else begin
            e = exp_q.pop_front();
            chk($sformatf("read %h", paddr), e[32:0],
                {pslverr, prdata & e[64:33]});
         end
      end
   end

   // Main sequence
   initial begin
      void'($urandom(32'h10000F79));
      repeat (20) @(posedge core_clk);
      reset_n <= 1'b1;
      @(posedge core_clk);
      rd(ssc_pkg::A_START, 32'(ssc_pkg::START_RST), F);
      rd(ssc_pkg::A_STOP, 32'(ssc_pkg::STOP_RST), F);
      rd(ssc_pkg::A_TDEF, 32'(ssc_pkg::TDEF_RST), F);
      rd(ST, 32'h0, 32'h0000000F);
      rd(12'h040, 32'h0, F, 1'b1);
      led(20, 0, 0);
      wr(ssc_pkg::A_TDEF, 32'h3);
      wr(ssc_pkg::A_STOP, 32'h0D);
      wr(ssc_pkg::A_REP, 32'h1);
      for (int i = 0; i < 3; i++) begin
         v[i] = 16'($urandom);
         c[i] = 16'($urandom);
         wr(ssc_pkg::A_LADDR, 32'(i + 11));
         wr(ssc_pkg::A_LVSET, 32'(v[i]));
         wr(ssc_pkg::A_LISET, 32'(c[i]));
         wr(ssc_pkg::A_LDWELL, (i < 2) ? 32'h000100FF : 32'h0);
         wr(ssc_pkg::A_LCTRL, 32'h1);
      end
      $display("test reset and store done");
      cmd(ssc_pkg::CMD_GO);
      rd(ST, 32'h0B09, S);
      rd(RR, 32'h1, F);
      rd(OP, {c[0], v[0]}, F);
      pins(v[0], c[0], 1'b1);
      cmd(ssc_pkg::CMD_HOLD);
      repeat (40) @(posedge core_clk);
      rd(ST, 32'h0B0A, S);
      rd(OP, {c[0], v[0]}, F);
      cmd(ssc_pkg::CMD_STEP);
      rd(ST, 32'h0C0E, S);
      rd(OP, {c[1], v[1]}, F);
      cmd(ssc_pkg::CMD_STEP);
      cmd(ssc_pkg::CMD_STEP);
      rd(ST, 32'h0B0E, S);
      rd(RR, 32'h1, F);
      wr(ssc_pkg::A_REP, 32'h2);
      cmd(ssc_pkg::CMD_STEP);
      cmd(ssc_pkg::CMD_START);
      rd(ST, 32'h0B0E, S);
      rd(RR, 32'h2, F);
      $display("test hold step start done");
      cmd(ssc_pkg::CMD_STEP);
      cmd(ssc_pkg::CMD_CONT);
      rd(ST, 32'h0D09, R);
      repeat (40) @(posedge core_clk);
      rd(ST, 32'h0B09, R);
      rd(RR, 32'h1, F);
      rd(OP, {c[0], v[0]}, F);
      led(30, 9, 10);
      key();
      key();
      rd(ST, 32'h0C09, R);
      cmd(ssc_pkg::CMD_STOP);
      rd(ST, 32'h0D08, R);
      rd(OP, {c[2], v[2]}, F);
      pins(v[2], c[2], 1'b1);
      led(30, 0, 0);
      $display("test resume key stop done");
      wr(ssc_pkg::A_REP, 32'h0);
      cmd(ssc_pkg::CMD_GO);
      cmd(ssc_pkg::CMD_HOLD);
      led(30, 4, 5);
      cmd(ssc_pkg::CMD_STEP);
      cmd(ssc_pkg::CMD_CONT);
      repeat (40) @(posedge core_clk);
      rd(ST, 32'h0D08, R);
      wr(ssc_pkg::A_STOP, 32'h0E);
      cmd(ssc_pkg::CMD_GO);
      cmd(ssc_pkg::CMD_HOLD);
      cmd(ssc_pkg::CMD_STOP);
      rd(ST, 32'h0, 32'h0000000B);
      rd(OP, {c[0], v[0]}, F);
      pins(v[0], c[0], 1'b0);
      cmd(ssc_pkg::CMD_GO);
      cmd(ssc_pkg::CMD_HOLD);
      cmd(ssc_pkg::CMD_ENDCUR);
      rd(ST, 32'h0B08, R);
      $display("test end paths done");
      wr(ssc_pkg::A_START, 32'h0A);
      cmd(ssc_pkg::CMD_GO);
      rd(ST, 32'h0, 32'h00000003);
      rd(EV, 32'h20, F);
      wr(EV, 32'h20);
      rd(EV, 32'h0, F);
      $display("test fault flag done");
      summarize();
   end
endmodule
`default_nettype wire
